// [rtc_pkg.sv]
`default_nettype none
package rtc_pkg;
	typedef enum logic [2:0] {RTC_DISABLED, RTC_ABOVE_ON, RTC_ABOVE_OFF, RTC_INSIDE, RTC_OUTSIDE} rtc_mode_e;
	typedef enum logic [1:0] {RTC_FAULT_HOLD, RTC_FAULT_ON, RTC_FAULT_OFF} rtc_fault_e;
	typedef struct packed {
		logic signed [15:0] firstThreshold;
		logic signed [15:0] secondThreshold;
		logic [15:0] hysteresisWidth;
		logic [15:0] onDelay;
		logic [15:0] offDelay;
		logic unitMinutes;
		rtc_mode_e mode;
		rtc_fault_e faultReaction;
	} rtc_cfg_s;
	typedef struct packed {
		logic sampleValid;
		logic signed [15:0] value;
		logic outOfRange;
	} rtc_sample_s;
endpackage : rtc_pkg
`default_nettype wire

// [rtc_regs.svh]
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH
// Overview of operation
// (R1) Each threshold gives two borders: threshold plus and minus hysteresis.
// (R2) Relay changes only after input stays beyond a border longer than the delay; code may switch up to one tick early.
// (R3) With both delays zero the relay switches at once on any border crossing.
// (R4) Positive on delay: energise only after staying beyond border for the delay; code may energise up to one tick early.
// (R5) Positive off delay: release once the delay elapsed since the border crossing; code may release up to one tick early.
// (R6) Return across the border before expiry keeps state and drops the change.
// (R7) Single threshold: direct energises above threshold, inverted de-energises there.
// (R8) Fault reaction forces relay on, off, or leaves it unchanged.
// (R9) Dual threshold shares hysteresis, delays, unit, polarity and fault reaction.
// (R10) Inside energises between thresholds, outside beyond them, off otherwise.
// (R11) Thresholds are sorted internally so either may be the larger.
// (R12) Disabled behaviour holds the relay permanently de-energised.
// (R13) Delays span 0 to 99.9 units in steps of 0.1.
// (R14) Time unit selects seconds or minutes for both delays.
// (R15) Critical situation is a value outside the permissible range.
// (R16) Borders evaluated per sample; delays count 0.1-unit ticks, restart on lapse.

// ----------------------------------------
// timing
// ----------------------------------------
`define RTC_CLK_HZ 100000000
`define RTC_TENTH_SEC_NS 100000000
`define RTC_CLK_NS 10
`define RTC_TENTH_SEC_CYC (`RTC_TENTH_SEC_NS / `RTC_CLK_NS)
`define RTC_SEC_PER_MIN 60
`define RTC_DELAY_MAX 16'h03E7
`endif

// [rtc_relay_threshold_control.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rtc_regs.svh"
module rtc_relay_threshold_control #(
	parameter int TENTH_CYCLES = `RTC_TENTH_SEC_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire rtc_pkg::rtc_cfg_s cfg,
	input wire rtc_pkg::rtc_sample_s sample,
	output logic relayOn,
	output logic ledOn,
	output logic critical,
	output logic delayPending
);
	// ----------------------------------------
	// 0.1-unit tick divider
	// ----------------------------------------
	logic [31:0] divCnt, next_divCnt;
	logic [5:0] minCnt, next_minCnt;
	logic tick;
	always_comb begin
		next_divCnt = divCnt + 32'h1;
		next_minCnt = minCnt;
		tick = 1'b0;
		if (divCnt >= 32'(TENTH_CYCLES - 1)) begin
			next_divCnt = '0;
			// minutes: 60 tenth-seconds per tenth-minute
			if (!cfg.unitMinutes || minCnt >= 6'(`RTC_SEC_PER_MIN - 1)) begin //R14
				tick = 1'b1;
				next_minCnt = '0;
			end else begin
				next_minCnt = minCnt + 6'h1;
			end
		end
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			divCnt <= '0;
			minCnt <= '0;
		end else begin
			divCnt <= next_divCnt;
			minCnt <= next_minCnt;
		end
	end

	// ----------------------------------------
	// border evaluation
	// ----------------------------------------
	function automatic logic signed [17:0] addSat(input logic signed [15:0] a, input logic signed [17:0] b);
		addSat = 18'(a) + b;
	endfunction : addSat

	function automatic logic [15:0] clampDelay(input logic [15:0] d);
		clampDelay = (d > 16'(`RTC_DELAY_MAX)) ? 16'(`RTC_DELAY_MAX) : d; //R13
	endfunction : clampDelay

	logic signed [15:0] loThr, hiThr;
	logic signed [17:0] hysteresis_width;
	logic [15:0] onLim, offLim;
	logic targetOn, targetOff;
	always_comb begin
		// sorted so either threshold may be larger
		if (cfg.firstThreshold <= cfg.secondThreshold) begin //R11
			loThr = cfg.firstThreshold;
			hiThr = cfg.secondThreshold;
		end else begin
			loThr = cfg.secondThreshold;
			hiThr = cfg.firstThreshold;
		end
		hysteresis_width = 18'(signed'({1'b0, cfg.hysteresisWidth}));
		// clamp delays to 99.9 units
		onLim = clampDelay(cfg.onDelay); //R13
		offLim = clampDelay(cfg.offDelay); //R13
		targetOn = 1'b0;
		targetOff = 1'b0;
		case (cfg.mode)
			rtc_pkg::RTC_ABOVE_ON: begin //R7
				targetOn = 18'(sample.value) > addSat(cfg.firstThreshold, hysteresis_width); //R1
				targetOff = 18'(sample.value) < addSat(cfg.firstThreshold, -hysteresis_width); //R1
			end
			rtc_pkg::RTC_ABOVE_OFF: begin //R7
				targetOff = 18'(sample.value) > addSat(cfg.firstThreshold, hysteresis_width);
				targetOn = 18'(sample.value) < addSat(cfg.firstThreshold, -hysteresis_width);
			end
			rtc_pkg::RTC_INSIDE: begin //R10 R9
				targetOn = 18'(sample.value) > addSat(loThr, hysteresis_width) && 18'(sample.value) < addSat(hiThr, -hysteresis_width);
				targetOff = 18'(sample.value) < addSat(loThr, -hysteresis_width) || 18'(sample.value) > addSat(hiThr, hysteresis_width);
			end
			rtc_pkg::RTC_OUTSIDE: begin //R10 R9
				targetOff = 18'(sample.value) > addSat(loThr, hysteresis_width) && 18'(sample.value) < addSat(hiThr, -hysteresis_width);
				targetOn = 18'(sample.value) < addSat(loThr, -hysteresis_width) || 18'(sample.value) > addSat(hiThr, hysteresis_width);
			end
			default: begin
				targetOn = 1'b0;
				targetOff = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// zone latch, per sample
	// ----------------------------------------
	logic wantOn, wantOff, next_wantOn, next_wantOff, next_critical;
	always_comb begin
		next_wantOn = wantOn;
		next_wantOff = wantOff;
		next_critical = critical;
		if (sample.sampleValid) begin //R16
			next_critical = sample.outOfRange && cfg.mode != rtc_pkg::RTC_DISABLED; //R15
			next_wantOn = targetOn && !sample.outOfRange;
			next_wantOff = targetOff && !sample.outOfRange;
		end
	end

	// ----------------------------------------
	// delay counter and relay state
	// ----------------------------------------
	logic [15:0] dlyCnt, next_dlyCnt;
	logic next_relayOn;
	logic crossing;
	logic [15:0] curLim;
	always_comb begin
		next_dlyCnt = dlyCnt;
		next_relayOn = relayOn;
		curLim = relayOn ? offLim : onLim;
		crossing = (wantOn && !relayOn) || (wantOff && relayOn);
		if (cfg.mode == rtc_pkg::RTC_DISABLED) begin //R12
			next_relayOn = 1'b0;
			next_dlyCnt = '0;
		end else if (critical) begin //R8
			next_dlyCnt = '0;
			if (cfg.faultReaction == rtc_pkg::RTC_FAULT_ON)
				next_relayOn = 1'b1;
			else if (cfg.faultReaction == rtc_pkg::RTC_FAULT_OFF)
				next_relayOn = 1'b0;
		end else if (!crossing) begin //R6
			next_dlyCnt = '0;
		end else if (curLim == 16'h0000) begin //R3
			next_relayOn = !relayOn;
			next_dlyCnt = '0;
		end else if (tick) begin //R16
			// switch on the tick that brings the count to curLim; the first tick can be partial, so the wait may be up to one tick short
			if (dlyCnt + 16'h1 >= curLim) begin //R2 R4 R5
				next_relayOn = !relayOn;
				next_dlyCnt = '0;
			end else begin
				next_dlyCnt = dlyCnt + 16'h1;
			end
		end
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wantOn <= 1'b0;
			wantOff <= 1'b0;
			critical <= 1'b0;
			dlyCnt <= '0;
			relayOn <= 1'b0;
		end else begin
			wantOn <= next_wantOn;
			wantOff <= next_wantOff;
			critical <= next_critical;
			dlyCnt <= next_dlyCnt;
			relayOn <= next_relayOn;
		end
	end
	assign ledOn = relayOn;
	assign delayPending = crossing && !critical && cfg.mode != rtc_pkg::RTC_DISABLED;

	// ----------------------------------------
	// reference borders for the checks
	// ----------------------------------------
	// wide enough that no border sum can wrap
	logic signed [31:0] refVal, refFirst, refLo, refHi, refHyst;
	always_comb begin
		refVal = 32'(sample.value);
		refFirst = 32'(cfg.firstThreshold);
		refHyst = $signed({16'h0000, cfg.hysteresisWidth});
		refLo = 32'(cfg.secondThreshold);
		refHi = 32'(cfg.firstThreshold);
		if (cfg.firstThreshold < cfg.secondThreshold) begin
			refLo = 32'(cfg.firstThreshold);
			refHi = 32'(cfg.secondThreshold);
		end
	end

	// ----------------------------------------
	// tick spacing monitor
	// ----------------------------------------
	// a unit change makes the next gap partial, so the check skips it
	logic [31:0] gapCnt, next_gapCnt;
	logic gapValid, next_gapValid, prevUnit;
	always_comb begin
		next_gapCnt = gapCnt + 32'h1;
		next_gapValid = gapValid;
		if (tick) begin
			next_gapCnt = 32'h1;
			next_gapValid = 1'b1;
		end
		if (cfg.unitMinutes != prevUnit) begin
			next_gapValid = 1'b0;
		end
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			gapCnt <= '0;
			gapValid <= 1'b0;
			prevUnit <= 1'b0;
		end else begin
			gapCnt <= next_gapCnt;
			gapValid <= next_gapValid;
			prevUnit <= cfg.unitMinutes;
		end
	end

	// ----------------------------------------
	// mode and fault checks
	// ----------------------------------------
	a_disabled_off: assert property (@(posedge core_clk) disable iff (rst) //R12
		cfg.mode == rtc_pkg::RTC_DISABLED |=> !relayOn) else $error("relay on while disabled");

	a_disabled_count: assert property (@(posedge core_clk) disable iff (rst) //R12
		cfg.mode == rtc_pkg::RTC_DISABLED |=> dlyCnt == 16'h0000) else $error("counter running while disabled");

	a_fault_on: assert property (@(posedge core_clk) disable iff (rst) //R8
		critical && cfg.mode != rtc_pkg::RTC_DISABLED && cfg.faultReaction == rtc_pkg::RTC_FAULT_ON |=> relayOn)
		else $error("fault on not forced");

	a_fault_off: assert property (@(posedge core_clk) disable iff (rst) //R8
		critical && cfg.faultReaction == rtc_pkg::RTC_FAULT_OFF |=> !relayOn) else $error("fault off not forced");

	a_hold_freeze: assert property (@(posedge core_clk) disable iff (rst) //R8
		critical && cfg.mode != rtc_pkg::RTC_DISABLED && cfg.faultReaction == rtc_pkg::RTC_FAULT_HOLD
		|=> relayOn == $past(relayOn)) else $error("relay moved under fault hold");

	a_crit_sample: assert property (@(posedge core_clk) disable iff (rst) //R15
		sample.sampleValid && sample.outOfRange && cfg.mode != rtc_pkg::RTC_DISABLED |=> critical)
		else $error("critical not flagged");

	a_oor_clears: assert property (@(posedge core_clk) disable iff (rst) //R15
		sample.sampleValid && sample.outOfRange |=> !wantOn && !wantOff) else $error("zone kept on bad sample");

	// ----------------------------------------
	// zone checks against the reference borders
	// ----------------------------------------
	a_border_on: assert property (@(posedge core_clk) disable iff (rst) //R1 R7
		sample.sampleValid && !sample.outOfRange && cfg.mode == rtc_pkg::RTC_ABOVE_ON && refVal > refFirst + refHyst
		|=> wantOn && !wantOff) else $error("upper border missed");

	a_border_off: assert property (@(posedge core_clk) disable iff (rst) //R1
		sample.sampleValid && !sample.outOfRange && cfg.mode == rtc_pkg::RTC_ABOVE_ON && refVal < refFirst - refHyst
		|=> wantOff && !wantOn) else $error("lower border missed");

	// strict borders: a value sitting on a border is still in the band
	a_dead_band: assert property (@(posedge core_clk) disable iff (rst) //R1 R6
		sample.sampleValid && cfg.mode == rtc_pkg::RTC_ABOVE_ON && refVal >= refFirst - refHyst
		&& refVal <= refFirst + refHyst |=> !wantOn && !wantOff) else $error("dead band not kept");

	a_inverted: assert property (@(posedge core_clk) disable iff (rst) //R7
		sample.sampleValid && !sample.outOfRange && cfg.mode == rtc_pkg::RTC_ABOVE_OFF && refVal > refFirst + refHyst
		|=> wantOff && !wantOn) else $error("inverted polarity wrong");

	a_inside_zone: assert property (@(posedge core_clk) disable iff (rst) //R10 R11
		sample.sampleValid && !sample.outOfRange && cfg.mode == rtc_pkg::RTC_INSIDE && refVal > refLo + refHyst
		&& refVal < refHi - refHyst |=> wantOn) else $error("inside zone missed");

	a_outside_zone: assert property (@(posedge core_clk) disable iff (rst) //R9 R10 R11
		sample.sampleValid && !sample.outOfRange && cfg.mode == rtc_pkg::RTC_OUTSIDE
		&& (refVal < refLo - refHyst || refVal > refHi + refHyst) |=> wantOn) else $error("outside zone missed");

	// ----------------------------------------
	// delay and timing checks
	// ----------------------------------------
	a_zero_delay: assert property (@(posedge core_clk) disable iff (rst) //R3
		!critical && cfg.mode != rtc_pkg::RTC_DISABLED && wantOn && !relayOn && onLim == 16'h0000 |=> relayOn)
		else $error("zero delay not immediate");

	a_no_spurious: assert property (@(posedge core_clk) disable iff (rst) //R6
		!critical && cfg.mode != rtc_pkg::RTC_DISABLED && !crossing |=> relayOn == $past(relayOn))
		else $error("relay changed without crossing");

	a_wait_tick: assert property (@(posedge core_clk) disable iff (rst) //R2 R4 R5
		!critical && cfg.mode != rtc_pkg::RTC_DISABLED && crossing && !tick && onLim != 16'h0000
		&& offLim != 16'h0000 |=> relayOn == $past(relayOn)) else $error("relay changed between ticks");

	a_restart_cnt: assert property (@(posedge core_clk) disable iff (rst) //R16
		!crossing |=> dlyCnt == 16'h0000) else $error("counter not restarted");

	a_clamp_limit: assert property (@(posedge core_clk) disable iff (rst) //R13
		onLim <= 16'(`RTC_DELAY_MAX) && offLim <= 16'(`RTC_DELAY_MAX)) else $error("delay limit not clamped");

	a_count_bound: assert property (@(posedge core_clk) disable iff (rst) //R13
		dlyCnt < 16'(`RTC_DELAY_MAX)) else $error("delay counter overran");

	a_tick_spacing: assert property (@(posedge core_clk) disable iff (rst) //R14 R16
		tick && gapValid && cfg.unitMinutes == prevUnit |-> gapCnt == (cfg.unitMinutes
		? 32'(TENTH_CYCLES * `RTC_SEC_PER_MIN) : 32'(TENTH_CYCLES))) else $error("tick spacing wrong");

	c_turn_on: cover property (@(posedge core_clk) disable iff (rst) !relayOn ##1 relayOn);
	c_turn_off: cover property (@(posedge core_clk) disable iff (rst) relayOn ##1 !relayOn);
	c_fault: cover property (@(posedge core_clk) disable iff (rst) critical);
	c_abort: cover property (@(posedge core_clk) disable iff (rst) delayPending && dlyCnt != 16'h0000 ##1 !delayPending);
	c_minute_tick: cover property (@(posedge core_clk) disable iff (rst) tick && cfg.unitMinutes);
endmodule : rtc_relay_threshold_control
`default_nettype wire

// [rtc_sample_src.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// measurement source, one-cycle sample pulses
// ----------------------------------------
module rtc_sample_src (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic go,
	input wire logic signed [15:0] val,
	input wire logic oor,
	output rtc_pkg::rtc_sample_s sample
);
	rtc_pkg::rtc_sample_s nextSample;
	// value not held between pulses, so a stale read shows up
	always_comb begin
		nextSample = '{1'b0, ~sample.value, ~sample.outOfRange};
		if (go) begin
			nextSample = '{1'b1, val, oor};
		end
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sample <= '0;
		end else begin
			sample <= nextSample;
		end
	end
endmodule : rtc_sample_src
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic go = 1'b0;
	logic oor = 1'b0;
	logic signed [15:0] val = 16'h0000;
	rtc_pkg::rtc_cfg_s cfg = '0;
	rtc_pkg::rtc_sample_s sample;
	logic relayOn, ledOn, critical, delayPending;
	int mismatches = 0;
	int checks = 0;
	rtc_sample_src rtc_sample_src_i (.core_clk(core_clk), .rst(rst), .go(go), .val(val), .oor(oor), .sample(sample));
	rtc_relay_threshold_control #(.TENTH_CYCLES(10)) rtc_relay_threshold_control_i (.core_clk(core_clk),
		.rst(rst), .cfg(cfg), .sample(sample), .relayOn(relayOn), .ledOn(ledOn), .critical(critical),
		.delayPending(delayPending));
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	task automatic print_verdict;
		if (mismatches == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input logic seen, input logic exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : chk
	task automatic after(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : after
	task automatic setCfg(input rtc_pkg::rtc_mode_e m, input int f, s, h, dOn, dOff, input logic mn,
		input rtc_pkg::rtc_fault_e fr);
		@(posedge core_clk);
		cfg <= '{f[15:0], s[15:0], h[15:0], dOn[15:0], dOff[15:0], mn, m, fr};
	endtask : setCfg
	// sample taken two edges after the request; relay moves two edges later
	task automatic send(input int v, input logic o);
		@(posedge core_clk);
		go <= 1'b1;
		val <= v[15:0];
		oor <= o;
		@(posedge core_clk);
		go <= 1'b0;
	endtask : send
	task automatic waitRelay(input logic exp, input int bound);
		int i;
		for (i = 0; i < bound && relayOn !== exp; i++) after(1);
		chk(relayOn, exp);
		if (relayOn !== exp) print_verdict();
	endtask : waitRelay
	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		setCfg(rtc_pkg::RTC_ABOVE_ON, 100, 0, 10, 0, 0, 0, rtc_pkg::RTC_FAULT_HOLD);
		send(111, 0); after(3); chk(relayOn, 1); chk(ledOn, 1);
		send(95, 0); after(3); chk(relayOn, 1);
		send(89, 0); after(3); chk(relayOn, 0);
		setCfg(rtc_pkg::RTC_ABOVE_OFF, 100, 0, 10, 0, 0, 0, rtc_pkg::RTC_FAULT_HOLD);
		send(85, 0); after(3); chk(relayOn, 1);
		send(150, 0); after(3); chk(relayOn, 0);
		setCfg(rtc_pkg::RTC_ABOVE_ON, 100, 0, 10, 3, 2, 0, rtc_pkg::RTC_FAULT_HOLD);
		send(150, 0); after(15); chk(relayOn, 0); chk(delayPending, 1);
		waitRelay(1, 30);
		send(85, 0); after(5); chk(relayOn, 1);
		waitRelay(0, 30);
		send(150, 0); after(10); send(85, 0); after(40); chk(relayOn, 0);
		// first tick is partial, so two ticks keep the early check safe
		setCfg(rtc_pkg::RTC_ABOVE_ON, 100, 0, 10, 2, 0, 1, rtc_pkg::RTC_FAULT_HOLD);
		send(150, 0); after(300); chk(relayOn, 0);
		waitRelay(1, 1300);
		setCfg(rtc_pkg::RTC_ABOVE_ON, 100, 0, 10, 65535, 0, 0, rtc_pkg::RTC_FAULT_HOLD);
		send(50, 0); after(3); chk(relayOn, 0);
		send(150, 0); after(9900); chk(relayOn, 0);
		waitRelay(1, 200);
		// thresholds swapped on purpose
		setCfg(rtc_pkg::RTC_INSIDE, 200, 100, 10, 0, 0, 0, rtc_pkg::RTC_FAULT_HOLD);
		send(150, 0); after(3); chk(relayOn, 1);
		send(50, 0); after(3); chk(relayOn, 0);
		setCfg(rtc_pkg::RTC_OUTSIDE, 200, 100, 10, 0, 0, 0, rtc_pkg::RTC_FAULT_HOLD);
		send(50, 0); after(3); chk(relayOn, 1);
		send(150, 0); after(3); chk(relayOn, 0);
		setCfg(rtc_pkg::RTC_ABOVE_ON, 100, 0, 10, 0, 0, 0, rtc_pkg::RTC_FAULT_ON);
		send(50, 1); after(3); chk(relayOn, 1); chk(critical, 1);
		setCfg(rtc_pkg::RTC_ABOVE_ON, 100, 0, 10, 0, 0, 0, rtc_pkg::RTC_FAULT_OFF);
		send(150, 0); after(3); chk(critical, 0);
		send(150, 1); after(3); chk(relayOn, 0);
		setCfg(rtc_pkg::RTC_ABOVE_ON, 100, 0, 10, 0, 0, 0, rtc_pkg::RTC_FAULT_HOLD);
		send(150, 1); after(3); chk(relayOn, 0);
		setCfg(rtc_pkg::RTC_DISABLED, 100, 0, 10, 0, 0, 0, rtc_pkg::RTC_FAULT_ON);
		send(150, 0); after(3); chk(relayOn, 0);
		send(0, 1); after(3); chk(relayOn, 0); chk(critical, 0);
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
